// ===== ssf_framer.sv
// Line framer: wraps each line in sync codes, inserts shutter waits,
// holds the width, lane rate and lane count settings.
// Assumes all inputs come from logic on the core clock.
`timescale 1ns/1ns
module ssf_framer (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_chip,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // frame and line control
  input wire logic [1:0] i_readout_mode,
  input wire logic i_frame_start,
  input wire logic i_crop_change,
  input wire logic i_shutter_release,
  input wire logic i_line_start,
  input wire logic i_line_valid,
  // pixel payload in
  input wire logic i_pix_valid,
  input wire logic [ssf_pkg::WORD_W-1:0] i_pix_data,
  input wire logic i_pix_last,
  output logic o_pix_ready,
  // framed words out
  output logic o_word_valid,
  output logic [ssf_pkg::WORD_W-1:0] o_word_data,
  output logic [ssf_pkg::KIND_W-1:0] o_word_kind,
  input wire logic i_word_ready,
  // lane setup and status
  output logic [7:0] o_lane_enable,
  output logic [3:0] o_lane_count,
  output logic [19:0] o_lane_rate_kbps,
  output logic [23:0] o_total_rate_kbps,
  output logic o_cfg_error,
  output logic o_wait_active,
  output logic o_frame_invalid
);
  import ssf_pkg::*;

  typedef struct packed {
    ssf_state_t st;
    ssf_state_t ret;
    logic [1:0] idx;
    logic inv;
    logic line_req;
    logic line_vld;
    logic sh_pend;
    logic crop_pend;
    logic frame_inv;
    logic [11:0] wcnt;
    logic [7:0] input_ref_clock;
    logic [1:0] rate;
    logic [1:0] cw;
    logic [2:0] lcnt;
    logic cfg_err;
    logic [7:0] rdata;
    logic [7:0] lane_en;
    logic [3:0] lane_n;
    logic [19:0] rate_kbps;
    logic [23:0] total;
  } ssf_core_t;

  ssf_core_t s_r;
  ssf_core_t s_nxt;
  logic [11:0] sync_word;
  logic [11:0] wait_len;
  logic [11:0] mask;
  logic push;
  logic [KIND_W-1:0] push_kind;
  logic [WORD_W-1:0] push_word;
  logic buf_rdy;
  logic pix_rdy;
  logic [KIND_W+WORD_W-1:0] buf_out;

  // sync word for the code being sent
  ssf_sync_word u_sync (
    .i_width_sel(s_r.cw),
    .i_is_end(s_r.st == ST_EAV),
    .i_invalid(s_r.inv),
    .i_index(s_r.idx),
    .o_word(sync_word)
  );

  // wait length chosen by readout mode
  always_comb begin
    unique case (i_readout_mode)
      MODE_SUB: wait_len = 12'(WAIT_SUB_CYC);
      MODE_ROI: wait_len = 12'(WAIT_ROI_CYC);
      default: wait_len = 12'(WAIT_ALL_CYC);
    endcase
  end

  // next state of the framer
  always_comb begin
    s_nxt = s_r;
    push = 1'b0;
    push_kind = KIND_IDLE;
    push_word = '0;
    pix_rdy = 1'b0;
    mask = ssf_width_mask(s_r.cw);
    // pending events; a new line or shutter event beats a clear in the same cycle
    if (i_line_start) begin
      s_nxt.line_req = 1'b1;
      s_nxt.line_vld = i_line_valid;
    end
    if (i_shutter_release) begin
      s_nxt.sh_pend = 1'b1;
    end
    if (i_crop_change) begin
      s_nxt.crop_pend = 1'b1;
    end
    // a crop change makes exactly the next frame invalid
    if (i_frame_start) begin
      s_nxt.frame_inv = s_r.crop_pend || i_crop_change;
      s_nxt.crop_pend = 1'b0;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        if (s_r.sh_pend) begin
          s_nxt.st = ST_WAIT;
          s_nxt.ret = ST_IDLE;
          s_nxt.wcnt = wait_len;
          s_nxt.sh_pend = i_shutter_release;
        end else if (s_r.line_req || i_line_start) begin
          s_nxt.st = ST_SAV;
          s_nxt.idx = 2'd0;
          s_nxt.inv = s_r.frame_inv ||
                      !(s_r.line_req ? s_r.line_vld : i_line_valid);
          s_nxt.line_req = s_r.line_req && i_line_start;
        end
      end
      ST_SAV, ST_EAV: begin
        if (buf_rdy) begin
          push = 1'b1;
          push_kind = KIND_SYNC;
          push_word = sync_word & mask;
          s_nxt.idx = s_r.idx + 2'd1;
          if (s_r.idx == 2'd3) begin
            s_nxt.st = (s_r.st == ST_SAV) ? ST_PAY : ST_IDLE;
            if (s_r.sh_pend) begin
              s_nxt.st = ST_WAIT;
              s_nxt.ret = (s_r.st == ST_SAV) ? ST_PAY : ST_IDLE;
              s_nxt.wcnt = wait_len;
              s_nxt.sh_pend = i_shutter_release;
            end
          end
        end
      end
      ST_PAY: begin
        if (s_r.sh_pend) begin
          s_nxt.st = ST_WAIT;
          s_nxt.ret = ST_PAY;
          s_nxt.wcnt = wait_len;
          s_nxt.sh_pend = i_shutter_release;
        end else begin
          pix_rdy = buf_rdy;
          if (i_pix_valid && buf_rdy) begin
            push = 1'b1;
            push_kind = KIND_PIX;
            push_word = i_pix_data & mask;
            if (i_pix_last) begin
              s_nxt.st = ST_EAV;
              s_nxt.idx = 2'd0;
            end
          end
        end
      end
      ST_WAIT: begin
        // idle filler only; sync codes held back
        if (buf_rdy) begin
          push = 1'b1;
          push_kind = KIND_IDLE;
        end
        s_nxt.wcnt = s_r.wcnt - 12'd1;
        if (s_r.wcnt == 12'd1) begin
          s_nxt.st = s_r.ret;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // register writes
    if (i_reg_wr) begin
      if (i_reg_chip == CHIP_CLK && i_reg_addr == ADDR_INPUT_REF_CLOCK_ST0) begin
        s_nxt.input_ref_clock = i_reg_wdata;
      end
      if (i_reg_chip == CHIP_CLK && i_reg_addr == ADDR_LANE_RATE) begin
        s_nxt.rate = i_reg_wdata[1:0];
      end
      if (i_reg_chip == CHIP_ADC && i_reg_addr == ADDR_CONV_WIDTH &&
          i_reg_wdata[CONV_WIDTH_LSB+:2] != 2'h3) begin
        s_nxt.cw = i_reg_wdata[CONV_WIDTH_LSB+:2];
      end
      // prohibited lane codes are refused and flagged
      if (i_reg_chip == CHIP_LANE && i_reg_addr == ADDR_LANE_COUNT) begin
        if (i_reg_wdata[2:0] == LCNT_8 || i_reg_wdata[2:0] == LCNT_4 ||
            i_reg_wdata[2:0] == LCNT_2) begin
          s_nxt.lcnt = i_reg_wdata[2:0];
          s_nxt.cfg_err = 1'b0;
        end else begin
          s_nxt.cfg_err = 1'b1;
        end
      end
    end
    // register reads, unmapped reads give zero
    if (i_reg_rd) begin
      s_nxt.rdata = 8'h00;
      if (i_reg_chip == CHIP_CLK && i_reg_addr == ADDR_INPUT_REF_CLOCK_ST0) begin
        s_nxt.rdata = s_r.input_ref_clock;
      end
      if (i_reg_chip == CHIP_CLK && i_reg_addr == ADDR_LANE_RATE) begin
        s_nxt.rdata = {6'h00, s_r.rate};
      end
      if (i_reg_chip == CHIP_ADC && i_reg_addr == ADDR_CONV_WIDTH) begin
        s_nxt.rdata = {2'h0, s_r.cw, 4'h0};
      end
      if (i_reg_chip == CHIP_LANE && i_reg_addr == ADDR_LANE_COUNT) begin
        s_nxt.rdata = {5'h00, s_r.lcnt};
      end
    end
    // lane decode from the settings
    unique case (s_r.lcnt)
      LCNT_4: begin
        s_nxt.lane_en = LANES_4_EN;
        s_nxt.lane_n = LANES_4;
      end
      LCNT_2: begin
        s_nxt.lane_en = LANES_2_EN;
        s_nxt.lane_n = LANES_2;
      end
      default: begin
        s_nxt.lane_en = LANES_8_EN;
        s_nxt.lane_n = LANES_8;
      end
    endcase
    unique case (s_r.rate)
      2'h0: s_nxt.rate_kbps = RATE0_KBPS;
      2'h1: s_nxt.rate_kbps = RATE1_KBPS;
      2'h2: s_nxt.rate_kbps = RATE2_KBPS;
      2'h3: s_nxt.rate_kbps = RATE3_KBPS;
    endcase
    s_nxt.total = 24'(s_r.rate_kbps) * 24'(s_r.lane_n);
  end

  // state register
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.ret <= ST_IDLE;
      s_r.input_ref_clock <= RST_INPUT_REF_CLOCK_ST0;
      s_r.rate <= RST_LANE_RATE;
      s_r.cw <= RST_CONV_WIDTH;
      s_r.lcnt <= RST_LANE_COUNT;
      s_r.lane_en <= LANES_8_EN;
      s_r.lane_n <= LANES_8;
      s_r.rate_kbps <= RATE2_KBPS;
    end else begin
      s_r <= s_nxt;
    end
  end

  // two-entry buffer keeps words when the lanes stall
  ssf_word_buf #(
    .W(KIND_W + WORD_W),
    .DEPTH(2)
  ) u_buf (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_in_valid(push),
    .i_in_data({push_kind, push_word}),
    .o_in_ready(buf_rdy),
    .o_out_valid(o_word_valid),
    .o_out_data(buf_out),
    .i_out_ready(i_word_ready)
  );

  // outputs
  assign o_word_kind = buf_out[KIND_W+WORD_W-1:WORD_W];
  assign o_word_data = buf_out[WORD_W-1:0];
  assign o_pix_ready = pix_rdy;
  assign o_reg_rdata = s_r.rdata;
  assign o_lane_enable = s_r.lane_en;
  assign o_lane_count = s_r.lane_n;
  assign o_lane_rate_kbps = s_r.rate_kbps;
  assign o_total_rate_kbps = s_r.total;
  assign o_cfg_error = s_r.cfg_err;
  assign o_wait_active = (s_r.st == ST_WAIT);
  assign o_frame_invalid = s_r.frame_inv;

  // checks on the framing sequence
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_sync_push(ssf_state_t st, logic [1:0] ix);
    push && s_r.st == st && s_r.idx == ix;
  endsequence

  sequence s_sav_done;
    s_sync_push(ST_SAV, 2'd3);
  endsequence

  a_sav_then_pay: assert property (s_sav_done |=>
      (s_r.st == ST_PAY || s_r.st == ST_WAIT))
    else $error("start code not followed by payload");

  a_last_then_eav: assert property (
      push && push_kind == KIND_PIX && i_pix_last |=>
      s_r.st == ST_EAV && s_r.idx == 2'd0)
    else $error("last pixel not followed by end code");

  a_sync_order: assert property (
      push && push_kind == KIND_SYNC |=> s_r.idx == 2'($past(s_r.idx) + 2'd1))
    else $error("sync words out of order");
  a_sync_first: assert property (
      push && push_kind == KIND_SYNC && s_r.idx == 2'd0 |->
      push_word == ssf_width_mask(s_r.cw))
    else $error("first sync word not all ones");
  a_sync_middle: assert property (
      push && push_kind == KIND_SYNC &&
      (s_r.idx == 2'd1 || s_r.idx == 2'd2) |-> push_word == 12'h000)
    else $error("middle sync word not zero");
  a_sav_valid: assert property (
      s_sav_done and (s_r.inv == 1'b0) |-> push_word ==
      (s_r.cw == WSEL_8 ? SAV_V_8 : s_r.cw == WSEL_12 ? SAV_V_12 : SAV_V_10))
    else $error("valid start code word four wrong");
  a_eav_valid: assert property (
      s_sync_push(ST_EAV, 2'd3) and (s_r.inv == 1'b0) |-> push_word ==
      (s_r.cw == WSEL_8 ? EAV_V_8 : s_r.cw == WSEL_12 ? EAV_V_12 : EAV_V_10))
    else $error("valid end code word four wrong");
  a_sav_invalid: assert property (
      s_sav_done and s_r.inv |-> push_word ==
      (s_r.cw == WSEL_8 ? SAV_I_8 : s_r.cw == WSEL_12 ? SAV_I_12 : SAV_I_10))
    else $error("invalid start code word four wrong");
  a_eav_invalid: assert property (
      s_sync_push(ST_EAV, 2'd3) and s_r.inv |-> push_word ==
      (s_r.cw == WSEL_8 ? EAV_I_8 : s_r.cw == WSEL_12 ? EAV_I_12 : EAV_I_10))
    else $error("invalid end code word four wrong");
  a_release_wait: assert property (
      s_r.sh_pend && s_r.st == ST_PAY |=> s_r.st == ST_WAIT &&
      s_r.wcnt == wait_len)
    else $error("shutter release did not start a wait");
  a_wait_quiet: assert property (
      s_r.st == ST_WAIT |-> !(push && push_kind == KIND_SYNC) && !pix_rdy)
    else $error("sync or pixel during shutter wait");
  a_crop_invalid: assert property (
      i_frame_start && (s_r.crop_pend || i_crop_change) |=> o_frame_invalid)
    else $error("crop change did not make frame invalid");

  a_rate_total: assert property (
      $stable(s_r.rate) && $stable(s_r.lcnt) [*3] |->
      o_total_rate_kbps == 24'(o_lane_rate_kbps) * 24'(o_lane_count))
    else $error("total rate mismatch");

  a_sync_width: assert property (
      push && push_kind == KIND_SYNC |->
      (push_word & ~ssf_width_mask(s_r.cw)) == 12'h000)
    else $error("sync word wider than conversion width");
endmodule

// ===== ssf_pkg.sv
// Constants, encodings and register map of the sensor serial line framer.
// Assumes one core clock domain; every user of the block imports this.
//
// Contract
// - sync code brackets every line payload
// - sync code is four words, fixed order
// - word one all ones, two three zero
// - valid start code fourth word per width
// - valid end code fourth word per width
// - invalid start code fourth word per width
// - invalid end code fourth word per width
// - shutter release inserts idle filler wait
// - wait length per mode, placed at release; a release during a sync code starts the wait after its fourth word
// - no sync codes during the wait
// - lane rate code 0 gives 594 Mbps
// - lane rate code 1 gives 297 Mbps
// - lane rate code 2 gives 891 Mbps
// - lane rate code 3 gives 445.5 Mbps
// - total rate is lane rate times lanes
// - lane code 0/2/3 gives 8/4/2 lanes
// - crop change yields one invalid frame
package ssf_pkg;
  // clock and word widths
  localparam int CLK_PERIOD_NS = 50;
  localparam int WORD_W = 12;
  localparam int KIND_W = 2;
  // register port: chip selects and offsets
  localparam logic [7:0] CHIP_CLK = 8'h02;
  localparam logic [7:0] CHIP_ADC = 8'h04;
  localparam logic [7:0] CHIP_LANE = 8'h0b;
  localparam logic [7:0] ADDR_INPUT_REF_CLOCK_ST0 = 8'h14;
  localparam logic [7:0] ADDR_LANE_RATE = 8'hdc;
  localparam logic [7:0] ADDR_CONV_WIDTH = 8'h00;
  localparam logic [7:0] ADDR_LANE_COUNT = 8'h04;
  localparam int CONV_WIDTH_LSB = 4;
  // values after reset
  localparam logic [7:0] RST_INPUT_REF_CLOCK_ST0 = 8'h0a;
  localparam logic [1:0] RST_LANE_RATE = 2'h2;
  localparam logic [1:0] RST_CONV_WIDTH = 2'h0;
  localparam logic [2:0] RST_LANE_COUNT = 3'h0;
  // conversion width codes
  localparam logic [1:0] WSEL_10 = 2'h0;
  localparam logic [1:0] WSEL_12 = 2'h1;
  localparam logic [1:0] WSEL_8 = 2'h2;
  // lane count codes and lane masks
  localparam logic [2:0] LCNT_8 = 3'h0;
  localparam logic [2:0] LCNT_4 = 3'h2;
  localparam logic [2:0] LCNT_2 = 3'h3;
  localparam logic [7:0] LANES_8_EN = 8'hff;
  localparam logic [7:0] LANES_4_EN = 8'h0f;
  localparam logic [7:0] LANES_2_EN = 8'h03;
  localparam logic [3:0] LANES_8 = 4'h8;
  localparam logic [3:0] LANES_4 = 4'h4;
  localparam logic [3:0] LANES_2 = 4'h2;
  // per-lane bit rate in kbit/s for each rate code
  localparam logic [19:0] RATE0_KBPS = 20'h91050;
  localparam logic [19:0] RATE1_KBPS = 20'h48828;
  localparam logic [19:0] RATE2_KBPS = 20'hd9878;
  localparam logic [19:0] RATE3_KBPS = 20'h6cc3c;
  // word masks per width
  localparam logic [11:0] MASK_8 = 12'h0ff;
  localparam logic [11:0] MASK_10 = 12'h3ff;
  localparam logic [11:0] MASK_12 = 12'hfff;
  // fourth sync words: start/end, valid/invalid, per width
  localparam logic [11:0] SAV_V_8 = 12'h080;
  localparam logic [11:0] SAV_V_10 = 12'h200;
  localparam logic [11:0] SAV_V_12 = 12'h800;
  localparam logic [11:0] EAV_V_8 = 12'h09d;
  localparam logic [11:0] EAV_V_10 = 12'h274;
  localparam logic [11:0] EAV_V_12 = 12'h9d0;
  localparam logic [11:0] SAV_I_8 = 12'h0ab;
  localparam logic [11:0] SAV_I_10 = 12'h2ac;
  localparam logic [11:0] SAV_I_12 = 12'hab0;
  localparam logic [11:0] EAV_I_8 = 12'h0b6;
  localparam logic [11:0] EAV_I_10 = 12'h2d8;
  localparam logic [11:0] EAV_I_12 = 12'hb60;
  // shutter stabilization wait per readout mode
  localparam int WAIT_ALL_NS = 10000;
  localparam int WAIT_SUB_NS = 6000;
  localparam int WAIT_ROI_NS = 8000;
  localparam int WAIT_ALL_CYC =
    (WAIT_ALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_SUB_CYC =
    (WAIT_SUB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_ROI_CYC =
    (WAIT_ROI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // readout modes and output word kinds
  localparam logic [1:0] MODE_ALL = 2'h0;
  localparam logic [1:0] MODE_SUB = 2'h1;
  localparam logic [1:0] MODE_ROI = 2'h2;
  localparam logic [1:0] KIND_IDLE = 2'h0;
  localparam logic [1:0] KIND_SYNC = 2'h1;
  localparam logic [1:0] KIND_PIX = 2'h2;

  // framer sequencing states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SAV = 5'b00010,
    ST_PAY = 5'b00100,
    ST_EAV = 5'b01000,
    ST_WAIT = 5'b10000
  } ssf_state_t;

  // valid bits of a word at the selected width
  function automatic logic [11:0] ssf_width_mask(input logic [1:0] cw);
    ssf_width_mask = (cw == WSEL_8) ? MASK_8 :
                     (cw == WSEL_12) ? MASK_12 : MASK_10;
  endfunction
endpackage

// ===== ssf_rx_model.sv
// Receiver model on the framed word stream of the line framer.
// Assumes valid/ready words on the core clock; can stall every other cycle.
`timescale 1ns/1ns
module ssf_rx_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // word stream
  input wire logic i_valid,
  input wire logic [11:0] i_data,
  input wire logic [1:0] i_kind,
  input wire logic i_slow,
  output logic o_ready
);
  import ssf_pkg::*;
  logic [13:0] words [0:255];
  int n_word;
  int n_sync;
  int n_idle;
  logic ph;
  // slow mode refuses every other cycle to exercise the buffer
  assign o_ready = !(i_slow && ph);
  // keep every sync and pixel word so the caller can judge lines; idle words are only counted
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ph <= 1'b0;
      n_word <= 0;
      n_sync <= 0;
      n_idle <= 0;
    end else begin
      ph <= !ph;
      if (i_valid && o_ready) begin
        if (i_kind == KIND_IDLE) n_idle <= n_idle + 1;
        else begin
          words[n_word[7:0]] <= {i_kind, i_data};
          n_word <= n_word + 1;
        end
        if (i_kind == KIND_SYNC) n_sync <= n_sync + 1;
      end
    end
  end
endmodule

// ===== ssf_sync_word.sv
// Sync code word table of the sensor serial line framer.
// Assumes a caller that steps the word index 0..3 in order.
`timescale 1ns/1ns
module ssf_sync_word (
  // code selection
  input wire logic [1:0] i_width_sel,
  input wire logic i_is_end,
  input wire logic i_invalid,
  input wire logic [1:0] i_index,
  // selected word, right aligned
  output logic [11:0] o_word
);
  import ssf_pkg::*;

  logic [11:0] fourth;

  // fourth word by code type and width
  always_comb begin
    unique case ({i_is_end, i_invalid})
      2'b00: fourth = (i_width_sel == WSEL_8) ? SAV_V_8 :
                      (i_width_sel == WSEL_12) ? SAV_V_12 : SAV_V_10;
      2'b10: fourth = (i_width_sel == WSEL_8) ? EAV_V_8 :
                      (i_width_sel == WSEL_12) ? EAV_V_12 : EAV_V_10;
      2'b01: fourth = (i_width_sel == WSEL_8) ? SAV_I_8 :
                      (i_width_sel == WSEL_12) ? SAV_I_12 : SAV_I_10;
      2'b11: fourth = (i_width_sel == WSEL_8) ? EAV_I_8 :
                      (i_width_sel == WSEL_12) ? EAV_I_12 : EAV_I_10;
    endcase
  end

  // first word all ones at width, middle words zero
  always_comb begin
    unique case (i_index)
      2'd0: o_word = ssf_width_mask(i_width_sel);
      2'd1, 2'd2: o_word = 12'h000;
      2'd3: o_word = fourth;
    endcase
  end
endmodule

// ===== ssf_word_buf.sv
// Small word buffer in front of the serial lanes.
// Assumes a drain side that may stall; full stalls the framer.
`timescale 1ns/1ns
module ssf_word_buf #(
  parameter int W = 14,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // filling side
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  // draining side
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } ssf_buf_state_t;

  ssf_buf_state_t s_r;
  ssf_buf_state_t s_nxt;
  logic wr;
  logic rd;

  // honest full and empty from the occupancy count
  assign o_in_ready = (s_r.cnt != CW'(DEPTH));
  assign o_out_valid = (s_r.cnt != '0);
  assign o_out_data = s_r.mem[s_r.rp];
  assign wr = i_in_valid && o_in_ready;
  assign rd = o_out_valid && i_out_ready;

  // pointer and count update
  always_comb begin
    s_nxt = s_r;
    if (wr) begin
      s_nxt.mem[s_r.wp] = i_in_data;
      s_nxt.wp = (s_r.wp == PW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (rd) begin
      s_nxt.rp = (s_r.rp == PW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    if (wr && !rd) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (rd && !wr) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== tb_top.sv
// Bench for the line framer: register tasks, line and shutter tests.
// Assumes the package and the receiver model are compiled first.
`timescale 1ns/1ns
module tb_top;
  import ssf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 0, rd = 0, fs = 0, cc = 0, sr = 0, ls = 0, lv = 0;
  logic pv = 0, pl = 0, slow = 0, rdy, wv, pr, cerr, wact, finv;
  logic [7:0] chip = 0, addr = 0, wd = 0, rdat, len;
  logic [1:0] mode = 0, kind;
  logic [11:0] pd = 0, wdat;
  logic [3:0] lcnt;
  logic [19:0] lrate;
  logic [23:0] total;
  int n_errors = 0, num_checks = 0, cyc = 0, t, n, sy, id;
  logic [19:0] rt [4] = '{RATE0_KBPS, RATE1_KBPS, RATE2_KBPS, RATE3_KBPS};
  logic [2:0] lc [3] = '{LCNT_8, LCNT_4, LCNT_2};
  logic [3:0] ln [3] = '{LANES_8, LANES_4, LANES_2};
  logic [7:0] le [3] = '{LANES_8_EN, LANES_4_EN, LANES_2_EN};
  logic [1:0] ws [3] = '{WSEL_8, WSEL_10, WSEL_12};
  logic [1:0] md [3] = '{MODE_ALL, MODE_SUB, MODE_ROI};
  int wc [3] = '{WAIT_ALL_CYC, WAIT_SUB_CYC, WAIT_ROI_CYC};
  ssf_framer i_ssf_framer (.i_core_clk(clk), .i_reset(rst),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_chip(chip), .i_reg_addr(addr),
    .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_readout_mode(mode),
    .i_frame_start(fs), .i_crop_change(cc), .i_shutter_release(sr),
    .i_line_start(ls), .i_line_valid(lv), .i_pix_valid(pv),
    .i_pix_data(pd), .i_pix_last(pl), .o_pix_ready(pr),
    .o_word_valid(wv), .o_word_data(wdat), .o_word_kind(kind),
    .i_word_ready(rdy), .o_lane_enable(len), .o_lane_count(lcnt),
    .o_lane_rate_kbps(lrate), .o_total_rate_kbps(total),
    .o_cfg_error(cerr), .o_wait_active(wact), .o_frame_invalid(finv));
  ssf_rx_model i_ssf_rx_model (.i_core_clk(clk), .i_reset(rst),
    .i_valid(wv), .i_data(wdat), .i_kind(kind), .i_slow(slow),
    .o_ready(rdy));
  // core clock
  initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wreg(logic [7:0] c, logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    {wr, chip, addr, wd} = {1'b1, c, a, d};
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rchk(logic [7:0] c, logic [7:0] a, logic [7:0] e);
    @(negedge clk);
    {rd, chip, addr} = {1'b1, c, a};
    @(negedge clk);
    rd = 0;
    chk("rdata", e, rdat);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  function automatic logic [11:0] c4(logic [1:0] w, logic en, logic inv);
    case ({en, inv})
      2'h0: c4 = w == WSEL_8 ? SAV_V_8 : w == WSEL_12 ? SAV_V_12 : SAV_V_10;
      2'h1: c4 = w == WSEL_8 ? SAV_I_8 : w == WSEL_12 ? SAV_I_12 : SAV_I_10;
      2'h2: c4 = w == WSEL_8 ? EAV_V_8 : w == WSEL_12 ? EAV_V_12 : EAV_V_10;
      default: c4 = w == WSEL_8 ? EAV_I_8 : w == WSEL_12 ? EAV_I_12 : EAV_I_10;
    endcase
  endfunction
  // one line of two pixels, then the ten framed words are compared
  task automatic line(logic v, logic [1:0] w, logic inv, logic sh = 0);
    int b;
    int q;
    logic [11:0] m;
    logic [13:0] e [10];
    b = i_ssf_rx_model.n_word;
    m = w == WSEL_8 ? 12'h0ff : w == WSEL_12 ? 12'hfff : 12'h3ff;
    e = '{{KIND_SYNC, m}, {KIND_SYNC, 12'h000}, {KIND_SYNC, 12'h000},
      {KIND_SYNC, c4(w, 0, inv)}, {KIND_PIX, 12'h055}, {KIND_PIX, 12'h02a},
      {KIND_SYNC, m}, {KIND_SYNC, 12'h000}, {KIND_SYNC, 12'h000},
      {KIND_SYNC, c4(w, 1, inv)}};
    lv = v;
    pulse(ls);
    // release the shutter while the payload is awaited
    if (sh) begin
      repeat (5) @(negedge clk);
      pulse(sr);
    end
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      {pv, pl, pd} = {1'b1, k == 1, e[4 + k][11:0]};
      q = 0;
      while (pr !== 1'b1 && q < 300) begin
        @(negedge clk);
        q++;
      end
      @(posedge clk);
    end
    @(negedge clk);
    {pv, pl} = 2'h0;
    q = 0;
    while (i_ssf_rx_model.n_word < b + 10 && q < 300) begin
      @(negedge clk);
      q++;
    end
    for (int k = 0; k < 10; k++)
      chk("word", e[k], i_ssf_rx_model.words[b + k]);
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    rchk(CHIP_CLK, ADDR_INPUT_REF_CLOCK_ST0, RST_INPUT_REF_CLOCK_ST0);
    rchk(CHIP_CLK, ADDR_LANE_RATE, 8'h02);
    rchk(8'h01, 8'h33, 8'h00);
    chk("rate", RATE2_KBPS, lrate);
    chk("total", RATE2_KBPS * 8, total);
    for (int r = 0; r < 4; r++) begin
      wreg(CHIP_CLK, ADDR_LANE_RATE, 8'(r));
      repeat (3) @(negedge clk);
      chk("rate", rt[r], lrate);
    end
    for (int k = 0; k < 3; k++) begin
      wreg(CHIP_LANE, ADDR_LANE_COUNT, {5'h00, lc[k]});
      repeat (3) @(negedge clk);
      chk("lanes", ln[k], lcnt);
      chk("enable", le[k], len);
      chk("total", 24'(RATE3_KBPS) * ln[k], total);
    end
    wreg(CHIP_LANE, ADDR_LANE_COUNT, 8'h01);
    repeat (3) @(negedge clk);
    chk("cfgerr", 1, cerr);
    chk("lanes", LANES_2, lcnt);
    wreg(CHIP_LANE, ADDR_LANE_COUNT, 8'h00);
    repeat (3) @(negedge clk);
    chk("cfgerr", 0, cerr);
    for (int k = 0; k < 3; k++) begin
      wreg(CHIP_ADC, ADDR_CONV_WIDTH, {2'h0, ws[k], 4'h0});
      slow = k == 1;
      line(1, ws[k], 0);
      line(0, ws[k], 1);
    end
    slow = 0;
    wreg(CHIP_ADC, ADDR_CONV_WIDTH, 8'h30);
    line(1, WSEL_12, 0);
    @(negedge clk);
    {cc, fs} = 2'h3;
    @(negedge clk);
    {cc, fs} = 2'h0;
    chk("finv", 1, finv);
    line(1, WSEL_12, 1);
    pulse(fs);
    @(negedge clk);
    chk("finv", 0, finv);
    line(1, WSEL_12, 0, 1);
    for (int k = 0; k < 3; k++) begin
      mode = md[k];
      sy = i_ssf_rx_model.n_sync;
      id = i_ssf_rx_model.n_idle;
      pulse(sr);
      n = 0;
      t = 0;
      while (t < 400 && (n == 0 || wact === 1'b1)) begin
        @(negedge clk);
        t++;
        if (wact === 1'b1) n++;
      end
      chk("wait", wc[k], n);
      chk("syncs", sy, i_ssf_rx_model.n_sync);
      chk("filler", 1, i_ssf_rx_model.n_idle > id);
    end
    wrap_up;
  end
endmodule
